// ### hdl/lwa_pkg.sv
// Constants for the lux window alert block: register map, field positions,
// reset values, exposure table and persistence timing.
// Assumes a 40 MHz system clock; the link side uses the same map.
package lwa_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] STAT_ADDR  = 8'h00;
    localparam logic [7:0] EN_ADDR    = 8'h01;
    localparam logic [7:0] CFG_ADDR   = 8'h02;
    localparam logic [7:0] LUXH_ADDR  = 8'h03;
    localparam logic [7:0] LUXL_ADDR  = 8'h04;
    localparam logic [7:0] UPPER_ADDR = 8'h05;
    localparam logic [7:0] LOWER_ADDR = 8'h06;
    localparam logic [7:0] TIMER_ADDR = 8'h07;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned EN_BIT     = 0;
    localparam int unsigned MANUAL_BIT = 6;
    localparam int unsigned CDR_BIT    = 3;
    localparam int unsigned TIM_MSB    = 2;

    // ----------------------------------------------------------------
    // Reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] UPPER_RST    = 8'hff;
    localparam logic [7:0] LOWER_RST    = 8'h00;
    localparam logic [7:0] TIMER_RST    = 8'hff;
    localparam logic [3:0] EXP_OVERLOAD = 4'hf;
    localparam logic [3:0] FILL_HI      = 4'hf;
    localparam logic [3:0] FILL_LO      = 4'h0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ  = 40_000_000;
    localparam int unsigned STEP_MS     = 100;
    localparam int unsigned STEP_CYCLES = STEP_MS * (SYS_CLK_HZ / 1000);

    // Integration time in microseconds per exposure code 0..7
    localparam logic [19:0] EXPO_US [8] = '{20'hc3500, 20'h61a80, 20'h30d40, 20'h186a0,
                                            20'h0c350, 20'h061a8, 20'h030d4, 20'h0186a};

endpackage : lwa_pkg

// ### hdl/lwa_xfer_if.sv
// Toggle handshake carrying one register access from link to core.
// Assumes the link end holds wr, addr and wdata stable while a request is open.
`timescale 1ns/1ps
interface lwa_xfer_if;
    logic       req_tgl;
    logic       ack_tgl;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport link (output req_tgl, wr, addr, wdata, input ack_tgl, rdata);
    modport core (input req_tgl, wr, addr, wdata, output ack_tgl, rdata);
endinterface : lwa_xfer_if

// ### hdl/lwa_link_port.sv
// Link-clock end of the register access crossing.
// Assumes the serial engine issues one access at a time on link_clk.
`timescale 1ns/1ps
module lwa_link_port
    import lwa_pkg::*;
(
    input  wire logic       link_clk,  // Link clock
    input  wire logic       rst,       // Async reset, active high
    lwa_xfer_if.link        xf,        // Crossing toward the core
    input  wire logic       acc_req,   // Access request pulse
    input  wire logic       acc_wr,    // 1 write, 0 read
    input  wire logic [7:0] acc_addr,  // Register address
    input  wire logic [7:0] acc_wdata, // Write data
    output logic            acc_busy,  // Access in flight
    output logic            acc_done,  // Access finished pulse
    output logic [7:0]      acc_rdata  // Read data, valid from done
);

    typedef struct packed {
        logic       busy;
        logic       done;
        logic       req;
        logic       ack_s1;
        logic       ack_s2;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } lwa_link_t;

    lwa_link_t st_q;
    lwa_link_t st_d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d        = st_q;
        st_d.done   = 1'b0;
        st_d.ack_s1 = xf.ack_tgl;
        st_d.ack_s2 = st_q.ack_s1;
        if (st_q.busy && (st_q.ack_s2 == st_q.req))
        begin
            st_d.busy  = 1'b0;
            st_d.done  = 1'b1;
            st_d.rdata = xf.rdata; // Stable: core set it on the same edge as the ack, two syncs ago
        end
        else if (!st_q.busy && acc_req)
        begin
            st_d.busy  = 1'b1;
            st_d.req   = ~st_q.req;
            st_d.wr    = acc_wr;
            st_d.addr  = acc_addr;
            st_d.wdata = acc_wdata;
        end
    end

    // State register
    always_ff @(posedge link_clk or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // Outputs straight from flops
    assign xf.req_tgl = st_q.req;
    assign xf.wr      = st_q.wr;
    assign xf.addr    = st_q.addr;
    assign xf.wdata   = st_q.wdata;
    assign acc_busy   = st_q.busy;
    assign acc_done   = st_q.done;
    assign acc_rdata  = st_q.rdata;

endmodule : lwa_link_port

// ### hdl/lwa_alert_top.sv
// Lux window alert: register file, window compare, persistence timer,
// open-drain alert pin and manual exposure selection.
// Assumes conversion results arrive on sys_clk; register accesses arrive
// from the serial engine on link_clk through lwa_link_port.
//
// How it works
// - Alerts raised only while enable bit set
// - Alert pin pulled low on alert condition
// - Status read or disable clears alert
// - Threshold byte: exponent nibble, significand top nibble
// - Lower threshold low nibble filled with zeros
// - Upper threshold low nibble filled with ones
// - Threshold equals significand times two^exponent
// - Count weight is base step times two^exponent
// - Manual overrange reports exponent fifteen
// - Exposure code picks time; divide coarsens eightfold
// - Resolution doubles with each range step
// - Persistence is timer times 100 ms
// - Alert when outside window long enough
// - Exponent fifteen reading is overload, ignored
`timescale 1ns/1ps
module lwa_alert_top
    import lwa_pkg::*;
#(
    parameter int unsigned STEP_CYC = STEP_CYCLES // Cycles per 100 ms step
)(
    input  wire logic        sys_clk,       // System clock, 40 MHz
    input  wire logic        rst,           // Async reset, active high
    input  wire logic        link_clk,      // Serial engine clock
    input  wire logic        acc_req,       // Access request pulse
    input  wire logic        acc_wr,        // 1 write, 0 read
    input  wire logic [7:0]  acc_addr,      // Register address
    input  wire logic [7:0]  acc_wdata,     // Write data
    output logic             acc_busy,      // Access in flight
    output logic             acc_done,      // Access finished pulse
    output logic [7:0]       acc_rdata,     // Read data
    input  wire logic        conv_valid,    // Conversion done pulse
    input  wire logic [3:0]  conv_exp,      // Result scale_power_bits
    input  wire logic [7:0]  conv_mant,     // Result significand
    input  wire logic        conv_over,     // Light above manual range
    input  wire logic [2:0]  auto_tim,      // Autorange exposure code
    input  wire logic        auto_cdr,      // Autorange divide choice
    input  wire logic        alert_in,      // Alert pin level, unused
    output logic             alert_out,     // Alert pin drive value
    output logic             alert_oe_n,    // Low while pulling pin low
    output logic [19:0]      integ_time_us, // Integration time to converter
    output logic             divide_on      // Current divide to converter
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        ack;
        logic [7:0]  rdata;
        logic        stat;
        logic        en;
        logic        manual;
        logic        current_divide_select;
        logic [2:0]  tim;
        logic [7:0]  upper;
        logic [7:0]  lower;
        logic [7:0]  timer;
        logic [3:0]  lux_exp;
        logic [7:0]  lux_mant;
        logic        outside;
        logic [21:0] tick;
        logic [7:0]  step;
        logic        pin_oe_n;
        logic        pin_out;
        logic [19:0] itime;
        logic        div;
    } lwa_core_t;

    lwa_core_t   st_q;
    lwa_core_t   st_d;
    lwa_xfer_if  xf ();

    logic [3:0]  rexp;
    logic [23:0] val;
    logic [23:0] up_v;
    logic [23:0] lo_v;
    logic        beyond;
    logic        conv_ok;
    logic        acc_go;
    logic        rd_stat;
    logic        dis_wr;
    logic        set_ev;

    // ----------------------------------------------------------------
    // Link side of the crossing
    // ----------------------------------------------------------------
    lwa_link_port u_link (
        .link_clk  (link_clk),
        .rst       (rst),
        .xf        (xf.link),
        .acc_req   (acc_req),
        .acc_wr    (acc_wr),
        .acc_addr  (acc_addr),
        .acc_wdata (acc_wdata),
        .acc_busy  (acc_busy),
        .acc_done  (acc_done),
        .acc_rdata (acc_rdata)
    );

    // ----------------------------------------------------------------
    // Window compare
    // ----------------------------------------------------------------
    // Both sides reduced to significand shifted by exponent, 23 bits max
    assign rexp    = (st_q.manual && conv_over) ? EXP_OVERLOAD : conv_exp;
    assign val     = 24'(conv_mant) << rexp;
    assign up_v    = 24'({st_q.upper[3:0], FILL_HI}) << st_q.upper[7:4];
    assign lo_v    = 24'({st_q.lower[3:0], FILL_LO}) << st_q.lower[7:4];
    assign beyond  = (val > up_v) || (val < lo_v);
    assign conv_ok = conv_valid && (rexp != EXP_OVERLOAD);

    // Access decode from the synchronised request toggle
    assign acc_go  = st_q.req_s2 != st_q.ack;
    assign rd_stat = acc_go && !xf.wr && (xf.addr == STAT_ADDR);
    assign dis_wr  = acc_go && xf.wr && (xf.addr == EN_ADDR) && !xf.wdata[EN_BIT];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d        = st_q;
        set_ev      = 1'b0;
        st_d.req_s1 = xf.req_tgl;
        st_d.req_s2 = st_q.req_s1;

        // Register access; data held by the link end until ack returns
        if (acc_go)
        begin
            st_d.ack = st_q.req_s2;
            if (xf.wr)
            begin
                case (xf.addr)
                    EN_ADDR:    st_d.en = xf.wdata[EN_BIT];
                    CFG_ADDR:
                    begin
                        st_d.manual = xf.wdata[MANUAL_BIT];
                        st_d.current_divide_select    = xf.wdata[CDR_BIT];
                        st_d.tim    = xf.wdata[TIM_MSB:0];
                    end
                    UPPER_ADDR: st_d.upper = xf.wdata;
                    LOWER_ADDR: st_d.lower = xf.wdata;
                    TIMER_ADDR: st_d.timer = xf.wdata;
                    default:    st_d.timer = st_q.timer; // Unmapped writes dropped
                endcase
            end
            else
            begin
                case (xf.addr)
                    STAT_ADDR:  st_d.rdata = {7'h00, st_q.stat};
                    EN_ADDR:    st_d.rdata = {7'h00, st_q.en};
                    CFG_ADDR:   st_d.rdata = {1'b0, st_q.manual, 2'b00, st_q.current_divide_select, st_q.tim};
                    LUXH_ADDR:  st_d.rdata = {st_q.lux_exp, st_q.lux_mant[7:4]};
                    LUXL_ADDR:  st_d.rdata = {4'h0, st_q.lux_mant[3:0]};
                    UPPER_ADDR: st_d.rdata = st_q.upper;
                    LOWER_ADDR: st_d.rdata = st_q.lower;
                    TIMER_ADDR: st_d.rdata = st_q.timer;
                    default:    st_d.rdata = 8'h00;
                endcase
            end
        end

        // Latest result, overloads included, for software to read
        if (conv_valid)
        begin
            st_d.lux_exp  = rexp;
            st_d.lux_mant = conv_mant;
        end

        // Persistence: 100 ms steps while outside; saturates so a long
        // stay never wraps back below the programmed count
        if (st_q.outside)
        begin
            if (st_q.tick == 22'(STEP_CYC - 1))
            begin
                st_d.tick = '0;
                if (st_q.step != 8'hff)
                    st_d.step = st_q.step + 8'h01;
            end
            else
                st_d.tick = st_q.tick + 22'h000001;
        end

        // Each valid conversion re-evaluates the window
        if (conv_ok)
        begin
            if (!beyond)
            begin
                st_d.outside = 1'b0;
                st_d.tick    = '0;
                st_d.step    = '0;
            end
            else if (!st_q.outside)
            begin
                st_d.outside = 1'b1;
                st_d.tick    = '0;
                st_d.step    = '0;
            end
        end

        // Zero timer fires on the first outside reading
        set_ev = st_d.en && st_d.outside && (st_d.step >= st_q.timer);

        // Status: set wins over a status read in the same cycle
        if (rd_stat || !st_d.en)
            st_d.stat = 1'b0;
        if (set_ev)
            st_d.stat = 1'b1;

        st_d.pin_oe_n = !st_d.stat;
        st_d.pin_out  = 1'b0;

        // Exposure: manual fields override autorange choices
        st_d.itime = EXPO_US[st_q.manual ? st_q.tim : auto_tim];
        st_d.div   = st_q.manual ? st_q.current_divide_select : auto_cdr;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q          <= '0;
            st_q.upper    <= UPPER_RST;
            st_q.lower    <= LOWER_RST;
            st_q.timer    <= TIMER_RST;
            st_q.pin_oe_n <= 1'b1;
            st_q.itime    <= EXPO_US[0];
        end
        else
            st_q <= st_d;
    end

    // Outputs straight from flops
    assign xf.ack_tgl    = st_q.ack;
    assign xf.rdata      = st_q.rdata;
    assign alert_out     = st_q.pin_out;
    assign alert_oe_n    = st_q.pin_oe_n;
    assign integ_time_us = st_q.itime;
    assign divide_on     = st_q.div;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_out_start;
        conv_ok && beyond && !st_q.outside;
    endsequence

    sequence s_back_in;
        conv_ok && !beyond;
    endsequence

    a_enable_gates: assert property (!st_q.en |-> !st_q.stat)
        else $error("alert status set while disabled");

    a_pin_tracks: assert property (alert_oe_n == !st_q.stat && alert_out == 1'b0)
        else $error("alert pin does not follow status");

    a_read_clears: assert property (rd_stat && !set_ev |=> !st_q.stat)
        else $error("status read did not clear alert");

    a_disable_clears: assert property (dis_wr |=> !st_q.stat && alert_oe_n)
        else $error("disable did not clear alert");

    a_zero_timer: assert property
        (s_out_start ##0 (st_q.en && st_q.timer == 8'h00 && !dis_wr) |=> st_q.stat && !alert_oe_n)
        else $error("zero timer alert not immediate");

    a_overload_skip: assert property
        (conv_valid && rexp == EXP_OVERLOAD |=> st_q.outside == $past(st_q.outside))
        else $error("overload reading moved window state");

    a_inside_restart: assert property (s_back_in |=> !st_q.outside && st_q.step == 8'h00)
        else $error("inside reading did not restart persistence");

    a_status_sticky: assert property (st_q.stat && !rd_stat && !dis_wr |=> st_q.stat)
        else $error("alert status dropped without clear");

    a_manual_ovld: assert property
        (conv_valid && st_q.manual && conv_over |=> st_q.lux_exp == EXP_OVERLOAD)
        else $error("manual overrange not reported");

    a_expo_map: assert property (st_q.manual |=> integ_time_us == EXPO_US[$past(st_q.tim)])
        else $error("exposure time does not match code");

endmodule : lwa_alert_top

// ### verif/lwa_host_model.sv
// Host side of the register access port: one access at a time on link_clk.
// Assumes the block answers each taken request with acc_done within 16 cycles.
`timescale 1ns/1ps
module lwa_host_model (
    input  wire logic       link_clk,  // Link clock
    input  wire logic       rst,       // Reset, active high
    output logic            acc_req,   // Access request pulse
    output logic            acc_wr,    // 1 write, 0 read
    output logic [7:0]      acc_addr,  // Register address
    output logic [7:0]      acc_wdata, // Write data
    input  wire logic       acc_busy,  // Access in flight
    input  wire logic       acc_done,  // Access finished
    input  wire logic [7:0] acc_rdata  // Read data
);
    // Idle values before the first access
    initial
    begin
        acc_req   = 1'b0;
        acc_wr    = 1'b0;
        acc_addr  = 8'h00;
        acc_wdata = 8'h00;
    end

    // Fields held until done, then inverted so nothing stale looks valid
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge link_clk);
        acc_req   <= 1'b1;
        acc_wr    <= wr;
        acc_addr  <= a;
        acc_wdata <= d;
        @(posedge link_clk);
        acc_req <= 1'b0;
        while (acc_done !== 1'b1 && n < 16)
        begin
            @(posedge link_clk);
            n++;
        end
        // A lost answer yields unknown data, which every compare rejects
        rd = (n < 16) ? acc_rdata : 8'hxx;
        acc_wr    <= ~wr;
        acc_addr  <= ~a;
        acc_wdata <= ~d;
    endtask : xfer
endmodule : lwa_host_model

// ### verif/testbench.sv
// Self-checking bench for the lux window alert block.
// Assumes a short persistence step (STEP cycles) and a free link clock.
`timescale 1ns/1ps
module testbench;
    import lwa_pkg::*;
    localparam int unsigned STEP = 20;
    logic        sys_clk  = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        acc_req, acc_wr, acc_busy, acc_done, alert_out, alert_oe_n, divide_on;
    logic [7:0]  acc_addr, acc_wdata, acc_rdata, rdv, up_b, lo_b;
    logic        conv_valid = 1'b0;
    logic        conv_over  = 1'b0;
    logic        auto_cdr   = 1'b0;
    logic [3:0]  conv_exp   = 4'h0;
    logic [7:0]  conv_mant  = 8'h00;
    logic [2:0]  auto_tim   = 3'h0;
    logic [19:0] integ_time_us;
    logic [31:0] seed       = 32'h160c;
    int          fails      = 0;
    int          total_checks = 0;
    int          expo_tab [8] = '{800000, 400000, 200000, 100000, 50000, 25000, 12500, 6250};
    logic [7:0]  ra [7] = '{STAT_ADDR, EN_ADDR, CFG_ADDR, UPPER_ADDR, LOWER_ADDR, TIMER_ADDR, 8'h08};
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
    // Pulled-up pin level seen by everyone
    wire  logic  alert_pin = alert_oe_n ? 1'b1 : alert_out;

    always #12.5 sys_clk = ~sys_clk;
    always #32 link_clk = ~link_clk;

    lwa_alert_top #(.STEP_CYC(STEP)) u_lwa_alert_top (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .acc_req(acc_req), .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_busy(acc_busy),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .conv_valid(conv_valid), .conv_exp(conv_exp),
        .conv_mant(conv_mant), .conv_over(conv_over), .auto_tim(auto_tim), .auto_cdr(auto_cdr),
        .alert_in(alert_pin), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
        .integ_time_us(integ_time_us), .divide_on(divide_on));
    lwa_host_model u_host (.link_clk(link_clk), .rst(rst), .acc_req(acc_req), .acc_wr(acc_wr),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_busy(acc_busy), .acc_done(acc_done),
        .acc_rdata(acc_rdata));

    // ----------------------------------------------------------------
    // Reference model and helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Threshold byte to count: low nibble padded per side
    function automatic longint thr(logic [7:0] b, bit hi);
        return longint'({b[3:0], hi ? 4'hf : 4'h0}) << b[7:4];
    endfunction : thr
    function automatic bit outside(logic [3:0] e, logic [7:0] m);
        longint v;
        v = longint'(m) << e;
        return (e != 4'hf) && (v > thr(up_b, 1'b1) || v < thr(lo_b, 1'b0));
    endfunction : outside
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    task automatic sw(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : sw
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer(1'b1, a, d, r);
        // A write that never finished comes back unknown
        chk("write answer", 32'(^r === 1'bx), 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 8'h00, rdv);
    endtask : rd
    // One conversion pulse, then the result lines are scrambled
    task automatic conv(input logic [3:0] e, input logic [7:0] m, input logic o);
        @(posedge sys_clk);
        conv_valid <= 1'b1;
        conv_exp   <= e;
        conv_mant  <= m;
        conv_over  <= o;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
        conv_exp   <= ~e;
        conv_mant  <= ~m;
        conv_over  <= 1'b0;
    endtask : conv
    task automatic final_report();
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // Watchdog well past the expected run length
    initial
    begin
        #2_000_000;
        fails++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [3:0] e, le, ue, ln, un;
        logic [7:0] m;
        bit         ex;
        // Slow clock sets the reset length so both domains see it
        repeat (3) @(posedge link_clk);
        @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            rd(ra[i]);
            chk("reset value", rdv, rv[i]);
            chk("busy idle", acc_busy, 32'h0);
        end
        $display("TEST reset values done");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            auto_tim <= 3'(xs());
            auto_cdr <= xs() > 32'h8000_0000;
            sw(4);
            chk("auto time", integ_time_us, expo_tab[auto_tim]);
            chk("auto divide", divide_on, auto_cdr);
        end
        // Manual codes override whatever autorange offers
        for (int i = 0; i < 16; i++)
        begin
            wr(CFG_ADDR, {2'b01, 2'b00, i[3], i[2:0]});
            sw(4);
            chk("manual time", integ_time_us, expo_tab[i[2:0]]);
            chk("manual divide", divide_on, i[3]);
        end
        conv(4'h3, 8'h5a, 1'b1);
        rd(LUXH_ADDR);
        chk("overload exp", rdv, 8'hf5);
        rd(LUXL_ADDR);
        chk("lux low", rdv, 8'h0a);
        wr(CFG_ADDR, 8'h00);
        conv(4'h2, 8'hc3, 1'b0);
        rd(LUXH_ADDR);
        chk("lux high", rdv, 8'h2c);
        $display("TEST exposure and result done");
        wr(TIMER_ADDR, 8'h00);
        repeat (24)
        begin
            // Host keeps exponents legal and top bit set when nonzero
            le = 4'(xs() % 15);
            ue = 4'(le + xs() % (15 - le));
            ln = 4'(xs());
            if (le != 4'h0) ln[3] = 1'b1;
            un = 4'(ln + xs() % (16 - ln));
            if (ue != 4'h0) un[3] = 1'b1;
            up_b = {ue, un};
            lo_b = {le, ln};
            // Disabled while the window moves, so no stale reading trips it
            wr(EN_ADDR, 8'h00);
            wr(UPPER_ADDR, up_b);
            wr(LOWER_ADDR, lo_b);
            conv(le, {ln, 4'h0}, 1'b0);
            wr(EN_ADDR, 8'h01);
            rd(UPPER_ADDR);
            chk("upper byte", rdv, up_b);
            e = (xs() % 8 == 0) ? 4'hf : 4'(xs() % 15);
            m = 8'(xs());
            ex = outside(e, m);
            conv(e, m, 1'b0);
            sw(3);
            chk("alert set", alert_pin, !ex);
            conv(le, {ln, 4'h0}, 1'b0);
            sw(3);
            chk("alert held", alert_pin, !ex);
            rd(STAT_ADDR);
            chk("status", rdv, {7'h00, ex});
            sw(4);
            chk("alert cleared", alert_pin, 1'b1);
        end
        $display("TEST window compare done");
        // Manual code 000, no divide: exponent zero stays inside its range
        wr(CFG_ADDR, 8'h40);
        wr(UPPER_ADDR, 8'h00);
        wr(LOWER_ADDR, 8'h00);
        conv(4'h0, 8'hc8, 1'b0);
        sw(3);
        chk("alert on", alert_pin, 1'b0);
        wr(EN_ADDR, 8'h00);
        sw(3);
        chk("disable release", alert_pin, 1'b1);
        conv(4'h0, 8'hc8, 1'b0);
        sw(3);
        chk("disabled pin", alert_pin, 1'b1);
        rd(STAT_ADDR);
        chk("disabled status", rdv, 8'h00);
        $display("TEST enable done");
        // Persistence of two steps: 2 * STEP cycles outside
        wr(TIMER_ADDR, 8'h02);
        conv(4'h0, 8'h0a, 1'b0);
        wr(EN_ADDR, 8'h01);
        conv(4'h0, 8'hc8, 1'b0);
        sw(30);
        chk("early alert", alert_pin, 1'b1);
        conv(4'h0, 8'h0a, 1'b0);
        conv(4'h0, 8'hc8, 1'b0);
        sw(30);
        chk("restart", alert_pin, 1'b1);
        sw(15);
        chk("late alert", alert_pin, 1'b0);
        rd(STAT_ADDR);
        chk("late status", rdv, 8'h01);
        $display("TEST persistence done");
        final_report();
    end
endmodule : testbench
